// [shared/mba_defines.svh]
`ifndef MBA_DEFINES_SVH
`define MBA_DEFINES_SVH

// clock and slot timing
`define MBA_CLK_PERIOD_NS   100
`define MBA_SLOT_TIME_US    2
// fixed slot length rounded up to whole clock cycles
`define MBA_SLOT_CYCLES     ((`MBA_SLOT_TIME_US * 1000 + `MBA_CLK_PERIOD_NS - 1) / `MBA_CLK_PERIOD_NS)

// interprocessor flag area, F200H to F2FFH
`define MBA_FLAG_PAGE       8'hf2
`define MBA_FLAG_PAGE_HI    15
`define MBA_FLAG_PAGE_LO    8
`define MBA_FLAG_BLOCK_HI   7
`define MBA_FLAG_BLOCK_LO   5
`define MBA_FLAG_OFFS_HI    7
`define MBA_FLAG_OFFS_LO    0

// reset values
`define MBA_GRANT_FIRST     4'h1
`define MBA_GRANT_NONE      4'h0
`define MBA_CPU_ALL         4'hf
`define MBA_IDX_FIRST       2'h0

`endif

// [shared/mba_pkg.sv]
package mba_pkg;

    // front selector position
    typedef enum logic [1:0] {
        MBA_SEL_STOP = 2'h0,
        MBA_SEL_RUN  = 2'h1,
        MBA_SEL_TEST = 2'h2
    } mba_sel_t;

    // coordinator operating state, one-hot
    typedef enum logic [2:0] {
        MBA_ST_STOP = 3'h1,
        MBA_ST_RUN  = 3'h2,
        MBA_ST_TEST = 3'h4
    } mba_state_t;

    // configuration straps, 1 = fitted
    typedef struct packed {
        logic       cnt_7_10;     // cpu count strap 7-10
        logic       cnt_8_9;      // cpu count strap 8-9
        logic       test_enable;  // test strap 3-14
        logic [7:0] flag_block;   // one enable per 32-byte flag block
    } mba_straps_t;

    // backplane memory access as seen by the flag decoder
    typedef struct packed {
        logic        req;         // read or write strobe active
        logic [15:0] addr;        // backplane address
    } mba_mem_t;

endpackage

// [design/mba_arbiter.sv]
//Contract
//RULE1: one grant at a time, cyclic order
//RULE2: each slot lasts fixed 2 us
//RULE3: first grant CPU 1, ascending, wrap
//RULE4: lock holds grant until operation ends
//RULE5: cpu count from two straps
//RULE6: stop at power-up or stop request
//RULE7: stop to run gives cold restart
//RULE8: resume only if cycling, all run, no stop
//RULE9: run at power-up gives automatic restart
//RULE10: test needs strap, stop-to-test cycles
//RULE11: test suppresses output disable for stopped
//RULE12: test error stops that CPU only
//RULE13: flag area decoded in eight gated blocks
//RULE14: blocks used by other modules masked out
//RULE15: rotation visits only configured CPUs
`timescale 1ns/1ps
`default_nettype none
`include "mba_defines.svh"

module mba_arbiter (
    input  wire logic                 ref_clk,
    input  wire logic                 reset_n,
    input  wire logic                 bus_lock,
    input  wire logic                 bus_cycle_busy,
    input  wire mba_pkg::mba_straps_t straps,
    input  wire mba_pkg::mba_sel_t    selector,
    input  wire logic [3:0]           cpu_selector_run,
    input  wire logic [3:0]           cpu_error,
    input  wire logic                 external_stop_request,
    input  wire logic                 cpu_reset_done,
    input  wire logic                 prior_cyclic,
    input  wire mba_pkg::mba_mem_t    mem,
    output logic [3:0]                cpu_bus_grant,
    output logic [3:0]                cpu_stop,
    output logic                      cold_restart,
    output logic                      warm_restart,
    output logic                      output_disable_command,
    output logic                      cycling_status,
    output logic                      interprocessor_flags_select,
    output logic [7:0]                interprocessor_flags_offset
);
    import mba_pkg::*;

    localparam logic [4:0] SLOT_LAST = 5'(`MBA_SLOT_CYCLES - 1);

    logic [4:0]  slot_cnt;      // cycles spent in current slot
    logic [1:0]  grant_idx;     // index of current owner
    logic [1:0]  last_idx;      // highest configured index
    logic        lock_seen;     // owner used the lock in this slot
    logic        slot_hold;     // slot end deferred by lock
    logic        slot_end;      // advance to next cpu this cycle
    logic [1:0]  next_idx;      // index after wrap
    mba_state_t  state;         // operating state
    mba_sel_t    sel_prev;      // selector one cycle ago
    logic        power_up;      // first cycle after reset release
    logic        was_cycling;   // cpus were in cyclic operation
    logic [3:0]  test_err;      // cpus stopped by error in test
    logic        all_run;       // every configured cpu selector at run
    logic        to_run;        // selector stop -> run
    logic        to_test;       // selector stop -> test
    logic        any_error;     // error from a configured cpu
    logic [3:0]  cfg_mask;      // configured cpu positions
    logic        flag_hit;      // address inside an enabled block

    // cpu count straps: both fitted 2, 7-10 only 3, 8-9 only 4
    always_comb
    begin
        unique case ({straps.cnt_7_10, straps.cnt_8_9})
            2'b11:   last_idx = 2'h1; // RULE5
            2'b10:   last_idx = 2'h2; // RULE5
            2'b01:   last_idx = 2'h3; // RULE5
            // no strap fitted is a wiring fault; fall back to two cpus
            default: last_idx = 2'h1;
        endcase
    end

    // mask of configured positions, used for the grant lines and the test-mode stop lines
    always_comb
    begin
        unique case (last_idx)
            2'h1:    cfg_mask = 4'h3;
            2'h2:    cfg_mask = 4'h7;
            default: cfg_mask = `MBA_CPU_ALL;
        endcase
    end

    // lock defers the slot end; once used, the grant also waits
    // for the running read or write to finish
    assign slot_hold = bus_lock | (lock_seen & bus_cycle_busy); // RULE4
    assign slot_end  = (slot_cnt >= SLOT_LAST) & ~slot_hold;    // RULE2

    // wrap after the last configured cpu back to cpu 1
    assign next_idx = (grant_idx >= last_idx) ? `MBA_IDX_FIRST
                                              : 2'(grant_idx + 2'h1); // RULE3 RULE15

    // slot timer, same length for every cpu
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            slot_cnt <= 5'h0;
        end
        else if (slot_end)
        begin
            slot_cnt <= 5'h0; // RULE2
        end
        else if (slot_cnt < SLOT_LAST)
        begin
            slot_cnt <= 5'(slot_cnt + 5'h1);
        end
    end

    // owner index; reset points at cpu 1
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            grant_idx <= `MBA_IDX_FIRST; // RULE3
        end
        else if (slot_end)
        begin
            grant_idx <= next_idx; // RULE1
        end
    end

    // remember lock use until the slot is handed on
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            lock_seen <= 1'b0;
        end
        else if (slot_end)
        begin
            lock_seen <= 1'b0;
        end
        else if (bus_lock)
        begin
            lock_seen <= 1'b1; // RULE4
        end
    end

    // grant lines, one-hot, registered; a handover gives one
    // cycle with no grant so two owners never overlap
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cpu_bus_grant <= `MBA_GRANT_NONE;
        end
        else if (slot_end)
        begin
            cpu_bus_grant <= `MBA_GRANT_NONE; // RULE1
        end
        else
        begin
            // only configured positions can be granted
            cpu_bus_grant <= (`MBA_GRANT_FIRST << grant_idx) & cfg_mask; // RULE1 RULE15
        end
    end

    // selector and cpu condition terms
    assign all_run   = &(cpu_selector_run | ~cfg_mask);
    assign to_run    = (sel_prev == MBA_SEL_STOP) & (selector == MBA_SEL_RUN);
    assign to_test   = (sel_prev == MBA_SEL_STOP) & (selector == MBA_SEL_TEST);
    assign any_error = |(cpu_error & cfg_mask);

    // selector history for edge detection
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sel_prev <= MBA_SEL_STOP;
        end
        else
        begin
            sel_prev <= selector;
        end
    end

    // marks the first clock after the power-supply reset ends
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            power_up <= 1'b1;
        end
        else
        begin
            power_up <= 1'b0;
        end
    end

    // operating state and restart pulses
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state        <= MBA_ST_STOP; // RULE6
            cold_restart <= 1'b0;
            warm_restart <= 1'b0;
        end
        else
        begin
            cold_restart <= 1'b0;
            warm_restart <= 1'b0;
            unique case (state)
                MBA_ST_STOP:
                begin
                    if (power_up)
                    begin
                        // selector at run when power comes up
                        if ((selector == MBA_SEL_RUN) && all_run && prior_cyclic
                            && !external_stop_request)
                        begin
                            state        <= MBA_ST_RUN; // RULE9
                            warm_restart <= 1'b1;       // RULE9
                        end
                    end
                    else if (external_stop_request)
                    begin
                        state <= MBA_ST_STOP; // RULE6
                    end
                    else if (to_run && was_cycling && all_run)
                    begin
                        // resume cyclic operation where it stopped
                        state        <= MBA_ST_RUN; // RULE8
                        warm_restart <= 1'b1;       // RULE8
                    end
                    else if (to_run && cpu_reset_done)
                    begin
                        state        <= MBA_ST_RUN; // RULE7
                        cold_restart <= 1'b1;       // RULE7
                    end
                    else if (to_test && straps.test_enable)
                    begin
                        // test is unreachable without the strap
                        state        <= MBA_ST_TEST; // RULE10
                        warm_restart <= 1'b1;        // RULE10
                    end
                end
                MBA_ST_RUN:
                begin
                    // any stop source or cpu error halts every cpu
                    if (external_stop_request || (selector != MBA_SEL_RUN) || any_error)
                    begin
                        state <= MBA_ST_STOP; // RULE6
                    end
                end
                MBA_ST_TEST:
                begin
                    // strap removal also ends test operation
                    if (external_stop_request || (selector != MBA_SEL_TEST)
                        || !straps.test_enable)
                    begin
                        state <= MBA_ST_STOP; // RULE6
                    end
                end
                default:
                begin
                    state <= MBA_ST_STOP;
                end
            endcase
        end
    end

    // retained cyclic-operation history; an error stop loses it,
    // so a later stop-to-run is a cold restart, not a resume
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            was_cycling <= 1'b0;
        end
        else if (power_up)
        begin
            was_cycling <= prior_cyclic; // RULE9
        end
        else if ((state == MBA_ST_RUN) && any_error)
        begin
            was_cycling <= 1'b0;
        end
        else if (state != MBA_ST_STOP)
        begin
            was_cycling <= 1'b1; // RULE8
        end
    end

    // per-cpu error stop in test; held while in test, cleared in every other state
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            test_err <= 4'h0;
        end
        else if (state == MBA_ST_TEST)
        begin
            test_err <= test_err | (cpu_error & cpu_selector_run & cfg_mask); // RULE12
        end
        else
        begin
            test_err <= 4'h0;
        end
    end

    // stop lines and output disable
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cpu_stop               <= `MBA_CPU_ALL;
            output_disable_command <= 1'b1;
            cycling_status         <= 1'b0;
        end
        else
        begin
            unique case (state)
                MBA_ST_RUN:
                begin
                    cpu_stop               <= 4'h0;
                    output_disable_command <= 1'b0;
                end
                MBA_ST_TEST:
                begin
                    // only cpus off at their switch, failed or not configured stay stopped
                    cpu_stop               <= ~cpu_selector_run | test_err | ~cfg_mask; // RULE12
                    // outputs stay enabled for switch-stopped cpus and errors
                    output_disable_command <= 1'b0; // RULE11 RULE12
                end
                default:
                begin
                    cpu_stop               <= `MBA_CPU_ALL; // RULE6
                    output_disable_command <= 1'b1;
                end
            endcase
            cycling_status <= (state != MBA_ST_STOP);
        end
    end

    // flag area: page F2, block enable strap per 32-byte block;
    // a removed strap leaves the block to another module
    assign flag_hit = mem.req
        && (mem.addr[`MBA_FLAG_PAGE_HI:`MBA_FLAG_PAGE_LO] == `MBA_FLAG_PAGE)
        && straps.flag_block[mem.addr[`MBA_FLAG_BLOCK_HI:`MBA_FLAG_BLOCK_LO]]; // RULE13 RULE14

    // registered select and byte offset into flag storage
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            interprocessor_flags_select <= 1'b0;
            interprocessor_flags_offset <= 8'h00;
        end
        else
        begin
            interprocessor_flags_select <= flag_hit; // RULE13
            interprocessor_flags_offset <= mem.addr[`MBA_FLAG_OFFS_HI:`MBA_FLAG_OFFS_LO];
        end
    end

endmodule
`default_nettype wire

// [verification/mba_arbiter_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module mba_arbiter_sva
    import mba_pkg::*;
(
    input wire logic                 ref_clk,
    input wire logic                 reset_n,
    input wire logic                 bus_lock,
    input wire logic                 bus_cycle_busy,
    input wire mba_pkg::mba_straps_t straps,
    input wire mba_pkg::mba_sel_t    selector,
    input wire logic                 external_stop_request,
    input wire logic                 cpu_reset_done,
    input wire mba_pkg::mba_mem_t    mem,
    input wire logic [3:0]           cpu_bus_grant,
    input wire logic [3:0]           cpu_stop,
    input wire logic                 cold_restart,
    input wire logic                 warm_restart,
    input wire logic                 output_disable_command,
    input wire logic                 cycling_status,
    input wire logic                 interprocessor_flags_select,
    input wire logic [7:0]           interprocessor_flags_offset
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    logic [3:0] last;  // latest grant seen
    logic [7:0] hold;  // cycles the grant has stood
    logic       lk;    // lock seen in this slot
    logic [3:0] top;   // highest configured grant
    logic [3:0] nxt;   // grant that must follow last
    logic       hit;   // access to an enabled flag block
    logic [7:0] low;   // low address byte

    // expected successor, from the count straps
    always_comb
    begin
        top = straps.cnt_7_10 ? (straps.cnt_8_9 ? 4'h2 : 4'h4) : (straps.cnt_8_9 ? 4'h8 : 4'h2);
        nxt = (last == 4'h0 || last == top) ? 4'h1 : last << 1;
        hit = mem.req && mem.addr[15:8] == 8'hf2 && straps.flag_block[mem.addr[7:5]];
        low = mem.addr[7:0];
    end

    // last owner, cleared by reset so cpu 1 is expected first
    always_ff @(posedge ref_clk or negedge reset_n)
        if (!reset_n) last <= 4'h0;
        else if (cpu_bus_grant != 4'h0) last <= cpu_bus_grant;

    // slot length, restarted in every gap
    always_ff @(posedge ref_clk or negedge reset_n)
        if (!reset_n) hold <= 8'h00;
        else if (cpu_bus_grant == 4'h0) hold <= 8'h00;
        else hold <= hold + 8'h01;

    // a locked slot may run long, so it is exempt from the length check
    always_ff @(posedge ref_clk or negedge reset_n)
        if (!reset_n) lk <= 1'b0;
        else if (cpu_bus_grant == 4'h0) lk <= 1'b0;
        else if (bus_lock) lk <= 1'b1;

    grant_onehot_a: assert property ($onehot0(cpu_bus_grant))
        else $error("more than one grant");
    grant_order_a: assert property (cpu_bus_grant != 4'h0 && cpu_bus_grant != last |-> cpu_bus_grant == nxt)
        else $error("grant out of order");
    slot_length_a: assert property (cpu_bus_grant == 4'h0 && $past(cpu_bus_grant) != 4'h0 && !lk |-> hold == 8'h13)
        else $error("slot length wrong");
    lock_hold_a: assert property (cpu_bus_grant != 4'h0 && bus_lock |=> $stable(cpu_bus_grant))
        else $error("grant moved under lock");
    busy_hold_a: assert property (cpu_bus_grant != 4'h0 && lk && bus_cycle_busy |=> $stable(cpu_bus_grant))
        else $error("grant moved mid access");
    // the first edge after a reset still shows the cleared flops, not the old address
    flag_select_a: assert property ($past(reset_n)
        |-> interprocessor_flags_select == $past(hit))
        else $error("flag select wrong");
    flag_offset_a: assert property ($past(reset_n)
        |-> interprocessor_flags_offset == $past(low))
        else $error("flag offset wrong");
    stop_all_a: assert property (external_stop_request |-> ##2 (cpu_stop == 4'hf && output_disable_command))
        else $error("stop request ignored");
    cold_start_a: assert property (selector == MBA_SEL_RUN && $past(selector) == MBA_SEL_STOP && cpu_reset_done
        && !external_stop_request && output_disable_command |=> cold_restart || warm_restart)
        else $error("no restart pulse");
    run_enable_a: assert property (cycling_status |-> !output_disable_command)
        else $error("outputs disabled while cycling");
endmodule

bind mba_arbiter mba_arbiter_sva chk (.*);
`default_nettype wire

// [verification/mba_cpu_model.sv]
`timescale 1ns/1ps
`default_nettype none
module mba_cpu_model (
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic [3:0] cpu_bus_grant,  // grants from the arbiter
    input  wire logic [3:0] lock_req,       // cpus that lock their slot
    input  wire logic [7:0] lock_len,       // lock length in cycles
    output logic            bus_lock,       // slot extension
    output logic            bus_cycle_busy  // access in progress
);
    logic [7:0] age;  // cycles into the grant
    logic       own;  // owner wants a locked access

    // age restarts in every handover gap
    always_ff @(posedge ref_clk or negedge reset_n)
        if (!reset_n) age <= 8'h00;
        else if (cpu_bus_grant == 4'h0) age <= 8'h00;
        else age <= age + 8'h01;

    // lines driven only by the owner; busy outlasts the lock a little
    always_comb
    begin
        own = (cpu_bus_grant & lock_req) != 4'h0;
        bus_lock = own && age < lock_len;
        bus_cycle_busy = own && age < lock_len + 8'h04;
    end
endmodule
`default_nettype wire

// [verification/test_multiprocessor_bus_arbiter.sv]
`timescale 1ns/1ps
`default_nettype none
module test_multiprocessor_bus_arbiter;
    import mba_pkg::*;
    logic        ref_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        bus_lock, busy;              // from cpu model
    logic        ext = 1'b0;                  // other stop request
    logic        rdone = 1'b0;                // cpus reset
    logic        prior = 1'b0;                // was cyclic
    logic        cold, warm, odis, cyc, fsel; // mode and flag outputs
    logic [3:0]  grant, stop;                 // per-cpu outputs
    logic [3:0]  err = 4'h0;                  // cpu errors
    logic [3:0]  crun = 4'hf;                 // cpu selectors at run
    logic [3:0]  lreq = 4'h0;                 // locking cpus
    logic [7:0]  llen = 8'h00;                // lock length
    logic [7:0]  foff;                        // flag offset
    mba_straps_t straps = {2'b11, 1'b0, 8'h0f};
    mba_sel_t    sel = MBA_SEL_STOP;
    mba_mem_t    mem = '0;
    int          n_mismatch = 0;
    int          comparisons = 0;
    int          nn [4] = '{2, 3, 4, 2};       // cpus per count strap pair
    // {select expected, req, addr}; upper four blocks masked
    logic [17:0] rows [8] = '{18'h3_f200, 18'h3_f27f, 18'h1_f280, 18'h1_f2ff,
                              18'h1_f1ff, 18'h1_f300, 18'h0_f210, 18'h3_f245};

    mba_arbiter uut (.ref_clk(ref_clk), .reset_n(reset_n), .bus_lock(bus_lock),
        .bus_cycle_busy(busy), .straps(straps), .selector(sel), .cpu_selector_run(crun),
        .cpu_error(err), .external_stop_request(ext), .cpu_reset_done(rdone),
        .prior_cyclic(prior), .mem(mem), .cpu_bus_grant(grant), .cpu_stop(stop),
        .cold_restart(cold), .warm_restart(warm), .output_disable_command(odis),
        .cycling_status(cyc), .interprocessor_flags_select(fsel),
        .interprocessor_flags_offset(foff));
    mba_cpu_model cpus (.ref_clk(ref_clk), .reset_n(reset_n), .cpu_bus_grant(grant),
        .lock_req(lreq), .lock_len(llen), .bus_lock(bus_lock), .bus_cycle_busy(busy));

    // free running clock
    initial
        forever #50 ref_clk = ~ref_clk;

    task automatic go(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic mode(input logic [3:0] s, input logic o, input logic c);
        check("cpu stop", 8'(s), 8'(stop));
        check("output disable", 8'(o), 8'(odis));
        check("cycling", 8'(c), 8'(cyc));
    endtask

    task automatic pulse(input logic c, input logic w);
        check("cold restart", 8'(c), 8'(cold));
        check("warm restart", 8'(w), 8'(warm));
    endtask

    task automatic do_reset;
        reset_n = 1'b0;
        go(6);
        reset_n = 1'b1;
    endtask

    task automatic finish_test;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // generous limit, the run needs well under a millisecond
    initial
    begin
        #5_000_000;
        n_mismatch++;
        finish_test;
    end

    initial
    begin
        go(3);
        mode(4'hf, 1'b1, 1'b0);
        check("grant", 8'h00, 8'(grant));
        go(3);
        reset_n = 1'b1;
        foreach (rows[i])
        begin
            mem = {rows[i][16], rows[i][15:0]};
            go(1);
            check("flag select", 8'(rows[i][17]), 8'(fsel));
            check("flag offset", rows[i][7:0], foff);
        end
        // every count strap pair, two rounds each
        for (int c = 0; c < 4; c++)
        begin
            {straps.cnt_7_10, straps.cnt_8_9} = 2'(3 - c);
            do_reset;
            go(1);
            for (int k = 0; k < 2 * nn[c]; k++)
            begin
                check("grant", 8'(4'h1 << (k % nn[c])), 8'(grant));
                go(18);
                check("grant", 8'(4'h1 << (k % nn[c])), 8'(grant));
                go(1);
                check("grant", 8'h00, 8'(grant));
                go(1);
            end
        end
        // locked slot runs past its 2 us, then until busy ends
        lreq = 4'h1;
        llen = 8'h1e;
        do_reset;
        go(34);
        check("grant", 8'h01, 8'(grant));
        go(3);
        check("grant", 8'h02, 8'(grant));
        lreq = 4'h0;
        straps.cnt_8_9 = 1'b1;
        straps.cnt_7_10 = 1'b1;
        do_reset;
        go(3);
        mode(4'hf, 1'b1, 1'b0);
        rdone = 1'b1;
        sel = MBA_SEL_RUN;
        go(1);
        pulse(1'b1, 1'b0);
        go(1);
        mode(4'h0, 1'b0, 1'b1);
        ext = 1'b1;
        go(2);
        mode(4'hf, 1'b1, 1'b0);
        ext = 1'b0;
        rdone = 1'b0;
        sel = MBA_SEL_STOP;
        go(2);
        sel = MBA_SEL_RUN;
        go(1);
        pulse(1'b0, 1'b1);
        go(1);
        mode(4'h0, 1'b0, 1'b1);
        // resume refused under a stop request, then with a cpu selector at stop
        sel = MBA_SEL_STOP;
        ext = 1'b1;
        go(2);
        sel = MBA_SEL_RUN;
        go(1);
        pulse(1'b0, 1'b0);
        ext = 1'b0;
        crun = 4'he;
        sel = MBA_SEL_STOP;
        go(2);
        sel = MBA_SEL_RUN;
        go(1);
        pulse(1'b0, 1'b0);
        go(1);
        mode(4'hf, 1'b1, 1'b0);
        crun = 4'hf;
        prior = 1'b1;
        do_reset;
        go(1);
        pulse(1'b0, 1'b1);
        go(1);
        mode(4'h0, 1'b0, 1'b1);
        prior = 1'b0;
        do_reset;
        go(1);
        pulse(1'b0, 1'b0);
        go(1);
        mode(4'hf, 1'b1, 1'b0);
        // test position ignored without its strap
        sel = MBA_SEL_STOP;
        go(2);
        sel = MBA_SEL_TEST;
        go(1);
        pulse(1'b0, 1'b0);
        straps.test_enable = 1'b1;
        sel = MBA_SEL_STOP;
        crun = 4'h3;
        go(2);
        sel = MBA_SEL_TEST;
        go(1);
        pulse(1'b0, 1'b1);
        go(1);
        mode(4'hc, 1'b0, 1'b1);
        // cpu 2 switched to stop: only it stops, outputs stay enabled
        crun = 4'h1;
        go(2);
        mode(4'he, 1'b0, 1'b1);
        crun = 4'h3;
        err = 4'h1;
        go(2);
        mode(4'hd, 1'b0, 1'b1);
        ext = 1'b1;
        go(2);
        mode(4'hf, 1'b1, 1'b0);
        finish_test;
    end
endmodule
`default_nettype wire
